// *** rtl/abg_defs.svh ***
/*
 Offsets, field positions, reset values and timing counts for the band gap
 enable and compare hit block. Assumes inclusion by bare name.
*/
`ifndef ABG_DEFS_SVH
`define ABG_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ABG_OFS_REF_EN     4'h0
`define ABG_OFS_HIT_LOW    4'h1
`define ABG_OFS_HIT_HIGH   4'h2
`define ABG_OFS_REQ_STAT   4'h3
`define ABG_OFS_IRQ_STAT   4'h4
`define ABG_OFS_IRQ_MASK   4'h5
`define ABG_OFS_MODE       4'h6

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define ABG_BIT_CONV_REF   2
`define ABG_BIT_CMP_REF    1
`define ABG_BIT_CORE_REF   0
`define ABG_REF_EN_MASK    16'h0007
`define ABG_RST_16         16'h0000
`define ABG_MODE_WRITE_HIT 2'h3
`define ABG_IRQ_MASK_BITS  16'h0003

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ABG_CLK_HZ         50000000
`define ABG_STARTUP_US     1000
`define ABG_STARTUP_CYC    ((`ABG_CLK_HZ / 1000000) * `ABG_STARTUP_US)

`endif

// *** rtl/abg_pkg.sv ***
/*
 Types for the band gap enable and compare hit block.
 Assumes nothing of its surroundings.
*/
package abg_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } abg_bus_t;

   typedef struct packed {
      logic [16:0] written;
      logic [16:0] match;
   } abg_evt_t;

   typedef enum logic [1:0] {
      ABG_REF_OFF,
      ABG_REF_STARTING,
      ABG_REF_READY
   } abg_ref_state_t;

endpackage : abg_pkg

// *** rtl/abg_ref_ctl.sv ***
/*
 One band gap reference: on while software enables it or a module asks,
 ready after the start-up count. Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "abg_defs.svh"

module abg_ref_ctl
   import abg_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = `ABG_STARTUP_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sw_en,
   input  wire logic mod_req,
   output var  logic ref_on,
   output var  logic ref_ready
);

   abg_ref_state_t state_q;
   abg_ref_state_t state_d;
   logic [31:0]    cnt_q;
   logic [31:0]    cnt_d;
   wire            want = sw_en | mod_req;
   wire            done = (cnt_q >= STARTUP_CYC - 32'd1);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ABG_REF_OFF: begin
            cnt_d = 32'h0000_0000;
            if (want) begin
               state_d = ABG_REF_STARTING;
            end
         end
         ABG_REF_STARTING: begin
            cnt_d = cnt_q + 32'h0000_0001;
            if (!want) begin
               state_d = ABG_REF_OFF;
            end else if (done) begin
               state_d = ABG_REF_READY;
            end
         end
         ABG_REF_READY: begin
            if (!want) begin
               state_d = ABG_REF_OFF;
            end
         end
         default: begin
            state_d = ABG_REF_OFF;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= ABG_REF_OFF;
         cnt_q     <= 32'h0000_0000;
         ref_on    <= 1'b0;
         ref_ready <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         ref_on    <= (state_d != ABG_REF_OFF);
         ref_ready <= (state_d == ABG_REF_READY);
      end
   end

endmodule : abg_ref_ctl
`default_nettype wire

// *** rtl/abg_top.sv ***
/*
 Band gap reference enables and per-channel compare hit flags of a
 converter, behind a simple strobe register port.
 Assumes one clock, synchronous inputs and event pulses from the
 converter's result and compare logic.
*/
// Local design decisions: the address-and-strobe port and the register addresses.
// What this block does
// R01: A module's request switches its band gap reference on by itself, usable after start-up.
// R02: Software should set the enable before the consumer to skip the roughly 1 ms wait.
// R03: With compare mode 11 a channel's hit flag sets on a buffer write or a match.
// R04: With compare mode 11 a clear hit flag means that buffer was not written.
// R05: With any other compare mode a hit flag sets only on a match.
// R06: With any other compare mode a clear hit flag means no match occurred.
// R07: Hit flags for channels 0 to 15 sit in bits 15 to 0 of the low hit register, reset zero, writable.
// R08: The channel 16 flag sits in bit 0 of the high hit register; bits 15 to 1 read zero.
// R09: Bits 15 to 3 of the band gap enable register read zero and ignore writes.
// R10: Bits 2, 1 and 0 enable the converter, comparator and core group references, reset zero.
// R11: A hit flag stays set until software writes zero; a same-cycle event wins over the clear.
`timescale 1ns/1ps
`default_nettype none
`include "abg_defs.svh"

module abg_top
   import abg_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = `ABG_STARTUP_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic [3:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output var  logic [15:0] RDATA,
   input  wire logic [1:0]  COMPARE_MODE_SELECT,
   input  wire logic [16:0] BUF_WRITTEN,
   input  wire logic [16:0] CMP_MATCH,
   input  wire logic [2:0]  REF_REQUEST,
   output var  logic [2:0]  REF_ON,
   output var  logic [2:0]  REF_READY,
   output var  logic        IRQ
);

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   abg_bus_t bus;
   abg_evt_t evt;

   assign bus.wr    = WR;
   assign bus.rd    = RD;
   assign bus.addr  = ADDR;
   assign bus.wdata = WDATA;
   assign evt.written = BUF_WRITTEN;
   assign evt.match   = CMP_MATCH;

   function automatic logic hit_wr(input abg_bus_t b, input logic [3:0] ofs);
      hit_wr = b.wr && (b.addr == ofs);
   endfunction : hit_wr

   wire wr_ref  = hit_wr(bus, `ABG_OFS_REF_EN);
   wire wr_lo   = hit_wr(bus, `ABG_OFS_HIT_LOW);
   wire wr_hi   = hit_wr(bus, `ABG_OFS_HIT_HIGH);
   wire wr_ist  = hit_wr(bus, `ABG_OFS_IRQ_STAT);
   wire wr_imsk = hit_wr(bus, `ABG_OFS_IRQ_MASK);

   // ---------------------------------------------------------------
   // Band gap enable register
   // ---------------------------------------------------------------
   logic [2:0] ref_en_q;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ref_en_q <= 3'h0;                                       // R10
      end else if (wr_ref) begin
         ref_en_q <= bus.wdata[2:0];                             // R09
      end
   end

   wire [15:0] ref_en_rd = {13'h0000, ref_en_q};               // R09

   // ---------------------------------------------------------------
   // Reference start-up, one per consumer group
   // ---------------------------------------------------------------
   logic [2:0] ref_on_w;
   logic [2:0] ref_ready_w;

   wire converter_ref_enable  = ref_en_q[`ABG_BIT_CONV_REF];   // R10
   wire comparator_ref_enable = ref_en_q[`ABG_BIT_CMP_REF];    // R10
   wire core_ref_group_enable = ref_en_q[`ABG_BIT_CORE_REF];   // R10

   // Converter reference
   abg_ref_ctl #(
      .STARTUP_CYC (STARTUP_CYC)
   ) u_ref_conv (
      .clk       (CLK),
      .rst_n     (RSTN),
      .sw_en     (converter_ref_enable),
      .mod_req   (REF_REQUEST[`ABG_BIT_CONV_REF]),               // R01
      .ref_on    (ref_on_w[`ABG_BIT_CONV_REF]),
      .ref_ready (ref_ready_w[`ABG_BIT_CONV_REF])
   );

   // Comparator reference
   abg_ref_ctl #(
      .STARTUP_CYC (STARTUP_CYC)
   ) u_ref_cmp (
      .clk       (CLK),
      .rst_n     (RSTN),
      .sw_en     (comparator_ref_enable),
      .mod_req   (REF_REQUEST[`ABG_BIT_CMP_REF]),                // R01
      .ref_on    (ref_on_w[`ABG_BIT_CMP_REF]),
      .ref_ready (ref_ready_w[`ABG_BIT_CMP_REF])
   );

   // Regulator, reset and oscillator group reference
   abg_ref_ctl #(
      .STARTUP_CYC (STARTUP_CYC)
   ) u_ref_core (
      .clk       (CLK),
      .rst_n     (RSTN),
      .sw_en     (core_ref_group_enable),
      .mod_req   (REF_REQUEST[`ABG_BIT_CORE_REF]),               // R01
      .ref_on    (ref_on_w[`ABG_BIT_CORE_REF]),
      .ref_ready (ref_ready_w[`ABG_BIT_CORE_REF])
   );

   // ---------------------------------------------------------------
   // Compare hit flags
   // ---------------------------------------------------------------
   logic [16:0] hit_q;
   logic [16:0] hit_d;
   logic [16:0] hit_set;
   logic [16:0] hit_keep;
   wire         write_mode = (COMPARE_MODE_SELECT == `ABG_MODE_WRITE_HIT);

   assign hit_set = write_mode ? (evt.written | evt.match)      // R03 R04
                               : evt.match;                     // R05 R06

   // A write replaces the stored flags; events then OR on top
   assign hit_keep[15:0] = wr_lo ? bus.wdata[15:0] : hit_q[15:0];  // R07
   assign hit_keep[16]   = wr_hi ? bus.wdata[0]    : hit_q[16];    // R08
   assign hit_d          = hit_keep | hit_set;                      // R11

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         hit_q <= 17'h0_0000;                                    // R07
      end else begin
         hit_q <= hit_d;
      end
   end

   wire [15:0] hit_lo_rd = hit_q[15:0];                         // R07
   wire [15:0] hit_hi_rd = {15'h0000, hit_q[16]};               // R08

   // ---------------------------------------------------------------
   // Interrupt status and mask
   // ---------------------------------------------------------------
   // Bit 0: any hit flag newly set; bit 1: a reference became ready
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [2:0] ready_prev_q;

   wire       hit_new    = |(hit_set & ~hit_q);
   wire       ready_rose = |(ref_ready_w & ~ready_prev_q);
   wire [1:0] irq_evt    = {ready_rose, hit_new};
   wire [1:0] irq_clr    = wr_ist ? bus.wdata[1:0] : 2'h0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_stat_q <= 2'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_mask_q <= 2'h0;
      end else if (wr_imsk) begin
         irq_mask_q <= bus.wdata[1:0];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ready_prev_q <= 3'h0;
      end else begin
         ready_prev_q <= ref_ready_w;
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   wire [15:0] req_stat_rd = {10'h000, ref_ready_w, ref_on_w};
   wire [15:0] irq_stat_rd = {14'h0000, irq_stat_q};
   wire [15:0] irq_mask_rd = {14'h0000, irq_mask_q};
   wire [15:0] mode_rd     = {14'h0000, COMPARE_MODE_SELECT};

   logic [15:0] rd_mux;

   always_comb begin
      case (bus.addr)
         `ABG_OFS_REF_EN:   rd_mux = ref_en_rd;
         `ABG_OFS_HIT_LOW:  rd_mux = hit_lo_rd;
         `ABG_OFS_HIT_HIGH: rd_mux = hit_hi_rd;
         `ABG_OFS_REQ_STAT: rd_mux = req_stat_rd;
         `ABG_OFS_IRQ_STAT: rd_mux = irq_stat_rd;
         `ABG_OFS_IRQ_MASK: rd_mux = irq_mask_rd;
         `ABG_OFS_MODE:     rd_mux = mode_rd;
         default:           rd_mux = 16'h0000;
      endcase
   end

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   // Read data stand one cycle, zero otherwise
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA <= 16'h0000;
      end else begin
         RDATA <= bus.rd ? rd_mux : 16'h0000;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         REF_ON <= 3'h0;
      end else begin
         REF_ON <= ref_on_w;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         REF_READY <= 3'h0;
      end else begin
         REF_READY <= ref_ready_w;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_q & irq_mask_q);
      end
   end

endmodule : abg_top
`default_nettype wire

// *** testbench/abg_top_sva.sv ***
/* Checker for the band gap and hit flag block.
   Sees only the top ports; one clock, reset active low. */
`timescale 1ns/1ps
`default_nettype none
`include "abg_defs.svh"
module abg_top_sva
   import abg_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = 8
) (
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic [3:0]  ADDR,
   input wire logic [15:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [15:0] RDATA,
   input wire logic [1:0]  COMPARE_MODE_SELECT,
   input wire logic [16:0] BUF_WRITTEN,
   input wire logic [16:0] CMP_MATCH,
   input wire logic [2:0]  REF_REQUEST,
   input wire logic [2:0]  REF_ON,
   input wire logic [2:0]  REF_READY,
   input wire logic        IRQ
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence rd_low;
      RD && ADDR == `ABG_OFS_HIT_LOW;
   endsequence
   sequence clr_low;
      WR && ADDR == `ABG_OFS_HIT_LOW && WDATA == 16'h0000 && CMP_MATCH == 17'h0_0000 &&
      (BUF_WRITTEN == 17'h0_0000 || COMPARE_MODE_SELECT != `ABG_MODE_WRITE_HIT);
   endsequence
   chk_hit_high_zero: assert property (RD && ADDR == `ABG_OFS_HIT_HIGH |=> RDATA[15:1] == 0)
      else $error("hit high upper bits not zero");
   chk_ref_en_zero: assert property (RD && ADDR == `ABG_OFS_REF_EN |=> RDATA[15:3] == 0)
      else $error("ref enable upper bits not zero");
   chk_ref_readback: assert property (WR && ADDR == `ABG_OFS_REF_EN ##1 RD &&
      ADDR == `ABG_OFS_REF_EN |=> RDATA == ($past(WDATA, 2) & `ABG_REF_EN_MASK))
      else $error("ref enable readback wrong");
   chk_req_turns_on: assert property (REF_REQUEST[2] [*4] |-> REF_ON[2])
      else $error("request did not power reference");
   chk_ready_waits: assert property ($rose(REF_ON[2]) |-> !REF_READY[2] [*6])
      else $error("reference ready before start-up");
   chk_match_sets: assert property (CMP_MATCH[3] ##1 rd_low |=> RDATA[3])
      else $error("match did not set hit flag");
   chk_write_mode: assert property (COMPARE_MODE_SELECT == `ABG_MODE_WRITE_HIT &&
      BUF_WRITTEN[5] ##1 rd_low |=> RDATA[5])
      else $error("buffer write did not set hit flag");
   chk_cleared_zero: assert property (clr_low ##1 rd_low |=> RDATA == 16'h0000)
      else $error("cleared hit flags not zero");
endmodule : abg_top_sva
bind abg_top abg_top_sva #(.STARTUP_CYC(STARTUP_CYC)) sva_u (.CLK(CLK), .RSTN(RSTN),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .COMPARE_MODE_SELECT(COMPARE_MODE_SELECT), .BUF_WRITTEN(BUF_WRITTEN),
   .CMP_MATCH(CMP_MATCH), .REF_REQUEST(REF_REQUEST), .REF_ON(REF_ON),
   .REF_READY(REF_READY), .IRQ(IRQ));
`default_nettype wire

// *** testbench/testbench.sv ***
/* Self-checking bench for the band gap and hit flag block.
   Drives all ports itself; start-up count shortened to 8. */
`timescale 1ns/1ps
`default_nettype none
`include "abg_defs.svh"
module testbench;
   import abg_pkg::*;
   logic        clk;
   logic        rst_n;
   logic        wr;
   logic        rd;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [1:0]  mode;
   logic [16:0] buf_written;
   logic [16:0] cmp_match;
   logic [2:0]  ref_req;
   logic [2:0]  ref_on;
   logic [2:0]  ref_ready;
   logic        irq;
   int          n_errors = 0;
   int          checks = 0;
   int          cyc_n = 0;
   abg_top #(.STARTUP_CYC(8)) dut_u (.CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .COMPARE_MODE_SELECT(mode), .BUF_WRITTEN(buf_written),
      .CMP_MATCH(cmp_match), .REF_REQUEST(ref_req), .REF_ON(ref_on), .REF_READY(ref_ready),
      .IRQ(irq));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 3000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // One bus cycle, optionally a write, with event pulses beside it
   task automatic cyc(input logic w, input logic [3:0] a, input logic [15:0] d,
                      input logic [16:0] bw, input logic [16:0] cm);
      @(posedge clk);
      wr <= w;
      addr <= a;
      wdata <= d;
      buf_written <= bw;
      cmp_match <= cm;
      @(posedge clk);
      wr <= 1'b0;
      buf_written <= 17'h0_0000;
      cmp_match <= 17'h0_0000;
   endtask : cyc
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp(rdata, e);
   endtask : rd_chk
   // Let n edges pass, then look once the outputs have settled
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   // Write, then read the same index in the very next cycle
   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp(rdata, e);
   endtask : wr_rd
   // Event pulses for one cycle, then a read in the next
   task automatic evt_rd(input logic [16:0] bw, input logic [16:0] cm, input logic [3:0] a,
                         input logic [15:0] e);
      @(posedge clk);
      buf_written <= bw;
      cmp_match <= cm;
      @(posedge clk);
      buf_written <= 17'h0_0000;
      cmp_match <= 17'h0_0000;
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp(rdata, e);
   endtask : evt_rd
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      mode = 2'h0;
      buf_written = 17'h0_0000;
      cmp_match = 17'h0_0000;
      ref_req = 3'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++) rd_chk(i[3:0], 16'h0000);
      wr_rd(`ABG_OFS_REF_EN, 16'hFFFF, 16'h0007);
      cyc(1'b1, `ABG_OFS_REF_EN, 16'h0000, 17'h0_0000, 17'h0_0000);
      cyc(1'b1, `ABG_OFS_HIT_LOW, 16'hA5A5, 17'h0_0000, 17'h0_0000);
      rd_chk(`ABG_OFS_HIT_LOW, 16'hA5A5);
      cyc(1'b1, `ABG_OFS_HIT_HIGH, 16'hFFFF, 17'h0_0000, 17'h0_0000);
      rd_chk(`ABG_OFS_HIT_HIGH, 16'h0001);
      cyc(1'b1, 4'hF, 16'hFFFF, 17'h0_0000, 17'h0_0000);
      rd_chk(4'hF, 16'h0000);
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         logic [15:0] lo_e;
         lo_e = (m == 3) ? 16'h002B : 16'h000A;
         @(posedge clk);
         mode <= m[1:0];
         cyc(1'b1, `ABG_OFS_HIT_HIGH, 16'h0000, 17'h0_0000, 17'h0_0000);
         wr_rd(`ABG_OFS_HIT_LOW, 16'h0000, 16'h0000);
         evt_rd(17'h1_0021, 17'h0_000A, `ABG_OFS_HIT_LOW, lo_e);
         rd_chk(`ABG_OFS_HIT_HIGH, (m == 3) ? 16'h0001 : 16'h0000);
      end
      $display("test compare modes done");
      cyc(1'b1, `ABG_OFS_HIT_LOW, 16'h0000, 17'h0_0000, 17'h0_0010);
      rd_chk(`ABG_OFS_HIT_LOW, 16'h0010);
      rd_chk(`ABG_OFS_HIT_LOW, 16'h0010);
      $display("test clear race done");
      cyc(1'b1, `ABG_OFS_REF_EN, 16'h0002, 17'h0_0000, 17'h0_0000);
      wait_cyc(12);
      cmp({13'h0000, ref_ready}, 16'h0002);
      @(posedge clk);
      ref_req <= 3'h6;
      wait_cyc(4);
      cmp({13'h0000, ref_on}, 16'h0006);
      cmp({13'h0000, ref_ready}, 16'h0002);
      wait_cyc(10);
      cmp({13'h0000, ref_ready}, 16'h0006);
      rd_chk(`ABG_OFS_REQ_STAT, 16'h0036);
      $display("test reference request done");
      cyc(1'b1, `ABG_OFS_IRQ_MASK, 16'h0000, 17'h0_0000, 17'h0_0000);
      rd_chk(`ABG_OFS_IRQ_STAT, 16'h0003);
      rd_chk(`ABG_OFS_MODE, 16'h0003);
      cyc(1'b1, `ABG_OFS_IRQ_STAT, 16'h0003, 17'h0_0000, 17'h0_0000);
      rd_chk(`ABG_OFS_IRQ_STAT, 16'h0000);
      cyc(1'b0, 4'h0, 16'h0000, 17'h0_0000, 17'h0_0001);
      wait_cyc(2);
      cmp({15'h0000, irq}, 16'h0000);
      cyc(1'b1, `ABG_OFS_IRQ_MASK, 16'h0001, 17'h0_0000, 17'h0_0000);
      wait_cyc(2);
      cmp({15'h0000, irq}, 16'h0001);
      cyc(1'b1, `ABG_OFS_IRQ_STAT, 16'h0001, 17'h0_0000, 17'h0_0000);
      wait_cyc(2);
      cmp({15'h0000, irq}, 16'h0000);
      $display("test interrupt done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
